// file: awm_cfg.svh
// Purpose: constants for the analog window monitor
// Assumes: 32-bit apb data, one word per register
// Notes:   offsets are byte addresses
`ifndef AWM_CFG_SVH
`define AWM_CFG_SVH
`define AWM_OFF_CTRL     12'h000
`define AWM_OFF_GAIN     12'h004
`define AWM_OFF_OFFSET   12'h008
`define AWM_OFF_MARG_HI  12'h00C
`define AWM_OFF_MARG_LO  12'h010
`define AWM_OFF_SAMPLE   12'h014
`define AWM_OFF_STATUS   12'h018
`define AWM_OFF_REF      12'h01C
`define AWM_OFF_LIVE     12'h020
`define AWM_OFF_IRQ_STAT 12'h024
`define AWM_OFF_IRQ_MASK 12'h028
`define AWM_OFF_BLKSEL   12'h02C
`define AWM_CTRL_EN_BIT      0
`define AWM_CTRL_RETAIN_BIT  1
`define AWM_CTRL_HI_EXT_BIT  2
`define AWM_CTRL_LO_EXT_BIT  3
`define AWM_CTRL_SRC_LSB     4
`define AWM_CTRL_DP_LSB      6
`define AWM_GAIN_MAX     16'sd1000
`define AWM_OFFSET_MAX   16'sd10000
`define AWM_MARGIN_MAX   16'd20000
`define AWM_RST_GAIN     16'sd100
`define AWM_IRQ_ALARM_SET 0
`define AWM_IRQ_ALARM_CLR 1
`define AWM_IRQ_CAPTURE   2
`endif

// file: awm_pkg.sv
// Purpose: types for the analog window monitor
// Assumes: nothing
// Notes:   none
package awm_pkg;
   typedef enum logic [1:0] {AWM_SRC_AIN, AWM_SRC_FLAG, AWM_SRC_BLOCK, AWM_SRC_AOUT} awm_src_type;
   typedef struct packed
   {
      logic signed [15:0] gain;
      logic signed [15:0] offset;
   } awm_scale_type;
   typedef struct packed
   {
      logic [15:0] hi;
      logic [15:0] lo;
   } awm_margin_type;
endpackage : awm_pkg

// file: awm_block_mem.sv
// Purpose: small memory of other blocks' actual values
// Assumes: written by software, read by block number
// Notes:   read data is registered, one cycle latency
`timescale 1ns/1ps
`default_nettype none
module awm_block_mem #(
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic              pclk,
   input  wire logic              wr_en,
   input  wire logic [AW-1:0]     wr_addr,
   input  wire logic [15:0]       wr_data,
   input  wire logic [AW-1:0]     rd_addr,
   output var  logic [15:0]       rd_data
);
   logic [15:0] mem [DEPTH];
   always_ff @(posedge pclk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
   end
endmodule : awm_block_mem
`default_nettype wire

// file: awm_monitor.sv
// Purpose: analog window monitor with apb register access
// Assumes: pclk 10 MHz, sources are synchronous to pclk
// Notes:   power_loss_n low models loss of power to the block state
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "awm_cfg.svh"
module awm_monitor
   import awm_pkg::*;
#(
   parameter int BLK_DEPTH = 16,
   parameter int BLK_AW    = 4
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cycle_tick,
   input  wire logic        enable_in,
   input  wire logic        power_loss_n,
   input  wire logic [15:0] analog_input_channel,
   input  wire logic [15:0] analog_flag,
   input  wire logic [15:0] analog_output_channel,
   output logic             alarm_out,
   output logic             irq
);
   logic [7:0]          ctrl_q;
   awm_scale_type       scale_q;
   awm_margin_type      marg_q;
   logic [15:0]         blk_sample_q;
   logic [31:0]         blk_sel_q;
   logic [2:0]          irq_stat_q;
   logic [2:0]          irq_mask_q;
   logic signed [15:0]  ref_raw_q;
   logic signed [31:0]  live_q;
   logic signed [31:0]  ref_q;
   logic                en_prev_q;
   logic                alarm_q;
   logic [15:0]         mem_rd;
   logic [BLK_AW-1:0]   mem_addr;
   logic                mem_wr;

   wire logic wr = psel & penable & pwrite;
   wire logic rd_acc = psel & penable & ~pwrite;
   assign pready = 1'b1;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= `AWM_OFF_BLKSEL);
   endfunction : mapped

   function automatic logic signed [15:0] clip_s(input logic signed [31:0] v, input logic signed [15:0] lim);
      if (v > lim)
         clip_s = lim;
      else if (v < -lim)
         clip_s = -lim;
      else
         clip_s = v[15:0];
   endfunction : clip_s

   function automatic logic signed [31:0] scale(input logic signed [15:0] raw, input awm_scale_type s);
      logic signed [31:0] p;
      p = (32'(raw) * 32'(s.gain)) / 32'sd100;
      scale = p + 32'(s.offset);
   endfunction : scale

   assign pslverr = psel & penable & ~mapped(paddr);

   // control, scaling and margin registers; kept through power loss, cleared only by presetn
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q       <= 8'h00;
         scale_q      <= '{gain: `AWM_RST_GAIN, offset: 16'sh0000};
         marg_q       <= '{hi: 16'h0000, lo: 16'h0000};
         blk_sample_q <= 16'h0000;
         blk_sel_q    <= 32'h0000_0000;
      end
      else if (wr && mapped(paddr))
      begin
         unique case (paddr)
            `AWM_OFF_CTRL:    ctrl_q <= pwdata[7:0];
            `AWM_OFF_GAIN:    scale_q.gain <= clip_s(pwdata, `AWM_GAIN_MAX);
            `AWM_OFF_OFFSET:  scale_q.offset <= clip_s(pwdata, `AWM_OFFSET_MAX);
            `AWM_OFF_MARG_HI: marg_q.hi <= (pwdata > 32'(`AWM_MARGIN_MAX)) ? `AWM_MARGIN_MAX : pwdata[15:0];
            `AWM_OFF_MARG_LO: marg_q.lo <= (pwdata > 32'(`AWM_MARGIN_MAX)) ? `AWM_MARGIN_MAX : pwdata[15:0];
            `AWM_OFF_SAMPLE:  blk_sample_q <= pwdata[15:0];
            `AWM_OFF_BLKSEL:  blk_sel_q <= pwdata;
            default: ;
         endcase
      end
   end

   // block value table: pwdata bits [BLK_AW+15:16] select entry on write
   assign mem_wr = wr && (paddr == `AWM_OFF_BLKSEL) && pwdata[31];
   assign mem_addr = mem_wr ? pwdata[16 +: BLK_AW] : blk_sel_q[BLK_AW-1:0];

   awm_block_mem #(.DEPTH(BLK_DEPTH), .AW(BLK_AW)) u_mem (
      .pclk    (pclk),
      .wr_en   (mem_wr),
      .wr_addr (pwdata[16 +: BLK_AW]),
      .wr_data (pwdata[15:0]),
      .rd_addr (mem_addr),
      .rd_data (mem_rd)
   );

   logic signed [15:0] sample;
   always_comb
   begin
      unique case (awm_src_type'(ctrl_q[`AWM_CTRL_SRC_LSB +: 2]))
         AWM_SRC_AIN:   sample = analog_input_channel;
         AWM_SRC_FLAG:  sample = analog_flag;
         AWM_SRC_BLOCK: sample = blk_sample_q;
         AWM_SRC_AOUT:  sample = analog_output_channel;
      endcase
   end

   // margins: fixed constant or another block's value, clamped to range
   logic [15:0] m_hi_raw;
   logic [15:0] m_lo_raw;
   logic signed [31:0] m_hi;
   logic signed [31:0] m_lo;
   always_comb
   begin
      m_hi_raw = ctrl_q[`AWM_CTRL_HI_EXT_BIT] ? mem_rd : marg_q.hi;
      m_lo_raw = ctrl_q[`AWM_CTRL_LO_EXT_BIT] ? mem_rd : marg_q.lo;
      m_hi = (m_hi_raw > `AWM_MARGIN_MAX) ? 32'(`AWM_MARGIN_MAX) : 32'(m_hi_raw);
      m_lo = (m_lo_raw > `AWM_MARGIN_MAX) ? 32'(`AWM_MARGIN_MAX) : 32'(m_lo_raw);
   end

   wire logic en_now = enable_in | ctrl_q[`AWM_CTRL_EN_BIT];
   wire logic rise   = cycle_tick & en_now & ~en_prev_q;
   wire logic signed [31:0] live_s = scale(sample, scale_q);
   wire logic signed [31:0] ref_s  = scale(ref_raw_q, scale_q);
   wire logic outside = (live_s > ref_s + m_hi) || (live_s < ref_s - m_lo);

   // monitor state; ref_raw_q, en_prev_q and alarm_q lost on power loss unless retention is selected
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_raw_q <= 16'sh0000;
         en_prev_q <= 1'b0;
         alarm_q   <= 1'b0;
         live_q    <= 32'sh0000_0000;
         ref_q     <= 32'sh0000_0000;
      end
      else if (!power_loss_n && !ctrl_q[`AWM_CTRL_RETAIN_BIT])
      begin
         ref_raw_q <= 16'sh0000;
         en_prev_q <= 1'b0;
         alarm_q   <= 1'b0;
      end
      else if (cycle_tick && power_loss_n)
      begin
         en_prev_q <= en_now;
         live_q    <= live_s;
         if (rise)
         begin
            ref_raw_q <= sample;
            ref_q     <= live_s;
            alarm_q   <= 1'b0;
         end
         else
         begin
            ref_q   <= ref_s;
            alarm_q <= en_now && outside;
         end
      end
   end
   assign alarm_out = alarm_q;

   // sticky events, write one to clear, set wins
   // a wipe on power loss also counts as the alarm clearing; a frozen block flags nothing
   logic [2:0] ev;
   wire logic tick_eval = cycle_tick & power_loss_n;
   wire logic wipe      = ~power_loss_n & ~ctrl_q[`AWM_CTRL_RETAIN_BIT];
   assign ev[`AWM_IRQ_ALARM_SET] = tick_eval & ~rise & en_now & outside & ~alarm_q;
   assign ev[`AWM_IRQ_ALARM_CLR] = alarm_q & (wipe | (tick_eval & (rise | ~(en_now & outside))));
   assign ev[`AWM_IRQ_CAPTURE]   = tick_eval & rise;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_q <= 3'h0;
         irq_mask_q <= 3'h0;
      end
      else
      begin
         if (wr && paddr == `AWM_OFF_IRQ_MASK)
            irq_mask_q <= pwdata[2:0];
         irq_stat_q <= (irq_stat_q & ~((wr && paddr == `AWM_OFF_IRQ_STAT) ? pwdata[2:0] : 3'h0)) | ev;
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   // read mux, registered data out
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            `AWM_OFF_CTRL:     prdata <= {24'h000000, ctrl_q};
            `AWM_OFF_GAIN:     prdata <= 32'(scale_q.gain);
            `AWM_OFF_OFFSET:   prdata <= 32'(scale_q.offset);
            `AWM_OFF_MARG_HI:  prdata <= {16'h0000, marg_q.hi};
            `AWM_OFF_MARG_LO:  prdata <= {16'h0000, marg_q.lo};
            `AWM_OFF_SAMPLE:   prdata <= {16'h0000, blk_sample_q};
            `AWM_OFF_STATUS:   prdata <= {29'h00000000, en_prev_q, en_now, alarm_q};
            `AWM_OFF_REF:      prdata <= ref_q;
            `AWM_OFF_LIVE:     prdata <= live_q;
            `AWM_OFF_IRQ_STAT: prdata <= {29'h00000000, irq_stat_q};
            `AWM_OFF_IRQ_MASK: prdata <= {29'h00000000, irq_mask_q};
            `AWM_OFF_BLKSEL:   prdata <= {16'h0000, mem_rd};
            default:           prdata <= 32'h0000_0000;
         endcase
      end
   end

   // assertions
   property p_alarm_low_when_off;
      @(posedge pclk) disable iff (!presetn)
      (cycle_tick && power_loss_n && !en_now) |=> !alarm_out;
   endproperty
   a_alarm_low_when_off: assert property (p_alarm_low_when_off) else $error("alarm high while disabled");

   property p_alarm_set;
      @(posedge pclk) disable iff (!presetn)
      (cycle_tick && power_loss_n && en_now && !rise && outside) |=> alarm_out;
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("alarm not set outside band");

   property p_inside_clear;
      @(posedge pclk) disable iff (!presetn)
      (cycle_tick && power_loss_n && !outside) |=> !alarm_out;
   endproperty
   a_inside_clear: assert property (p_inside_clear) else $error("alarm high inside band");

   property p_capture;
      @(posedge pclk) disable iff (!presetn)
      (rise && power_loss_n) |=> (ref_raw_q == $past(sample));
   endproperty
   a_capture: assert property (p_capture) else $error("reference not captured");

   property p_ref_hold;
      @(posedge pclk) disable iff (!presetn)
      (!rise && power_loss_n) |=> $stable(ref_raw_q);
   endproperty
   a_ref_hold: assert property (p_ref_hold) else $error("reference changed without edge");

   property p_margin_range;
      @(posedge pclk) disable iff (!presetn)
      (marg_q.hi <= `AWM_MARGIN_MAX) && (marg_q.lo <= `AWM_MARGIN_MAX);
   endproperty
   a_margin_range: assert property (p_margin_range) else $error("margin out of range");

   property p_gain_range;
      @(posedge pclk) disable iff (!presetn)
      (scale_q.gain <= `AWM_GAIN_MAX) && (scale_q.gain >= -`AWM_GAIN_MAX)
      && (scale_q.offset <= `AWM_OFFSET_MAX) && (scale_q.offset >= -`AWM_OFFSET_MAX);
   endproperty
   a_gain_range: assert property (p_gain_range) else $error("gain or offset out of range");

   property p_live_scaled;
      @(posedge pclk) disable iff (!presetn)
      (cycle_tick && power_loss_n) |=> (live_q == $past(live_s));
   endproperty
   a_live_scaled: assert property (p_live_scaled) else $error("live value not updated");

   property p_power_loss;
      @(posedge pclk) disable iff (!presetn)
      (!power_loss_n && !ctrl_q[`AWM_CTRL_RETAIN_BIT]) |=> (!alarm_out && ref_raw_q == 16'sh0000);
   endproperty
   a_power_loss: assert property (p_power_loss) else $error("state kept without retention");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      (irq_stat_q[`AWM_IRQ_ALARM_SET] && irq_mask_q[`AWM_IRQ_ALARM_SET]) |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised");

   // status bits stay until software writes a one to them
   property p_stat_sticky;
      @(posedge pclk) disable iff (!presetn)
      !(wr && paddr == `AWM_OFF_IRQ_STAT) |=> ((irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q));
   endproperty
   a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost without clear");

   property p_stat_w1c;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `AWM_OFF_IRQ_STAT) |=> ((irq_stat_q & $past(pwdata[2:0]) & ~$past(ev)) == 3'h0);
   endproperty
   a_stat_w1c: assert property (p_stat_w1c) else $error("status bit not cleared by write");

   property p_rise_flag;
      @(posedge pclk) disable iff (!presetn)
      $rose(alarm_out) |-> irq_stat_q[`AWM_IRQ_ALARM_SET];
   endproperty
   a_rise_flag: assert property (p_rise_flag) else $error("alarm set event not flagged");

   property p_fall_flag;
      @(posedge pclk) disable iff (!presetn)
      $fell(alarm_out) |-> irq_stat_q[`AWM_IRQ_ALARM_CLR];
   endproperty
   a_fall_flag: assert property (p_fall_flag) else $error("alarm clear event not flagged");

   property p_capture_flag;
      @(posedge pclk) disable iff (!presetn)
      (rise && power_loss_n) |=> irq_stat_q[`AWM_IRQ_CAPTURE];
   endproperty
   a_capture_flag: assert property (p_capture_flag) else $error("capture event not flagged");

   property p_unmapped_read;
      @(posedge pclk) disable iff (!presetn)
      (rd_acc && !mapped(paddr)) |-> (prdata == 32'h0000_0000 && pslverr);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused");

   c_capture: cover property (@(posedge pclk) disable iff (!presetn) rise ##[1:50] alarm_out);
   c_clear:   cover property (@(posedge pclk) disable iff (!presetn) alarm_out ##1 !alarm_out);
   c_retain:  cover property (@(posedge pclk) disable iff (!presetn) !power_loss_n && ctrl_q[`AWM_CTRL_RETAIN_BIT]);
   c_ext_margin: cover property (@(posedge pclk) disable iff (!presetn) ctrl_q[`AWM_CTRL_HI_EXT_BIT] && alarm_out);
endmodule : awm_monitor
`default_nettype wire

// file: test_analog_window_monitor.sv
// Purpose: self-checking bench for the analog window monitor
// Assumes: zero-wait apb slave, alarm valid one cycle after the tick edge
// Notes:   random samples from a fixed seed, boundary cases by hand
`timescale 1ns/1ps
`default_nettype none
`include "awm_cfg.svh"
module test_analog_window_monitor
   import awm_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        cycle_tick = 1'b0, enable_in = 1'b0, power_loss_n = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] ain = 16'h0, aflag = 16'h0, aout = 16'h0;
   logic        pready, pslverr, alarm_out, irq, er, prev = 1'b0, exp_a = 1'b0;
   logic [7:0]  ctrl = 8'h00;
   int          errors = 0, cmp_count = 0, g = 100, off = 0, hi = 0, lo = 0, refr = 0, smp = 0;
   int          g_tab [3] = '{100, 250, -50};
   int          b_tab [5] = '{551, 449, 552, 520, 448};

   awm_monitor uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cycle_tick(cycle_tick), .enable_in(enable_in), .power_loss_n(power_loss_n),
      .analog_input_channel(ain), .analog_flag(aflag), .analog_output_channel(aout),
      .alarm_out(alarm_out), .irq(irq));

   always #50 pclk = ~pclk;

   task automatic finish_test();
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // request held until pready is sampled high; data taken at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      forever
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [15:0] exp);
      apb(1'b0, a, 32'h0);
      chk({16'h0, rd[15:0]}, {16'h0, exp});
   endtask : rdchk

   function automatic int scl(input int raw);
      return raw * g / 100 + off;
   endfunction : scl

   function automatic int sample();
      case (ctrl[5:4])
         2'd0: return int'($signed(ain));
         2'd1: return int'($signed(aflag));
         2'd2: return smp;
         default: return int'($signed(aout));
      endcase
   endfunction : sample

   task automatic tick();
      int  s, h, l;
      logic en;
      @(posedge pclk);
      cycle_tick <= 1'b1;
      @(posedge pclk);
      cycle_tick <= 1'b0;
      @(posedge pclk);
      en = enable_in | ctrl[0];
      s = sample();
      h = ctrl[2] ? 51 : hi;
      l = ctrl[3] ? 51 : lo;
      if (en && !prev)
      begin
         refr = s;
         exp_a = 1'b0;
      end
      else
         exp_a = en && (scl(s) > scl(refr) + h || scl(s) < scl(refr) - l);
      prev = en;
      chk(alarm_out, exp_a);
   endtask : tick

   task automatic drive(input int v);
      ain <= 16'(v);
      aflag <= 16'(v + 7);
      aout <= 16'(v - 3);
      smp = v + 11;
      apb(1'b1, `AWM_OFF_SAMPLE, 32'(smp));
   endtask : drive

   initial
   begin
      #(100 * 40000);
      errors++;
      finish_test();
   end

   initial
   begin
      void'($urandom(32'hA2005299));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({alarm_out, irq}, 2'b00);
      rdchk(`AWM_OFF_GAIN, 16'h0064);
      apb(1'b1, `AWM_OFF_GAIN, 32'd2000);
      rdchk(`AWM_OFF_GAIN, 16'h03E8);
      apb(1'b1, `AWM_OFF_GAIN, -32'sd2000);
      rdchk(`AWM_OFF_GAIN, 16'hFC18);
      apb(1'b1, `AWM_OFF_OFFSET, 32'd20000);
      rdchk(`AWM_OFF_OFFSET, 16'h2710);
      apb(1'b1, `AWM_OFF_MARG_HI, 32'd30000);
      rdchk(`AWM_OFF_MARG_HI, 16'h4E20);
      apb(1'b0, 12'h030, 32'h0);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
      // every source with each of three fixed gains, random decimals setting, offset and margins
      foreach (g_tab[i])
         for (int sr = 0; sr < 4; sr++)
         begin
            g = g_tab[i];
            off = $urandom_range(1000) - 500;
            hi = $urandom_range(200);
            lo = $urandom_range(200);
            ctrl = {2'($urandom_range(3)), 2'(sr), 4'h0};
            apb(1'b1, `AWM_OFF_GAIN, 32'(g));
            apb(1'b1, `AWM_OFF_OFFSET, 32'(off));
            apb(1'b1, `AWM_OFF_MARG_HI, 32'(hi));
            apb(1'b1, `AWM_OFF_MARG_LO, 32'(lo));
            apb(1'b1, `AWM_OFF_CTRL, 32'(ctrl));
            enable_in <= 1'b0;
            tick();
            for (int k = 0; k < 8; k++)
            begin
               drive($urandom_range(1000));
               enable_in <= (k != 7);
               tick();
            end
         end
      // band edges with margins from a block and software enable
      g = 100;
      off = 0;
      hi = 0;
      lo = 0;
      apb(1'b1, `AWM_OFF_GAIN, 32'd100);
      apb(1'b1, `AWM_OFF_OFFSET, 32'd0);
      apb(1'b1, `AWM_OFF_MARG_HI, 32'd0);
      apb(1'b1, `AWM_OFF_MARG_LO, 32'd0);
      apb(1'b1, `AWM_OFF_BLKSEL, 32'h8003_0033);
      apb(1'b1, `AWM_OFF_IRQ_MASK, 32'h1);
      ctrl = 8'h0D;
      drive(500);
      apb(1'b1, `AWM_OFF_CTRL, 32'(ctrl));
      tick();
      apb(1'b1, `AWM_OFF_IRQ_STAT, 32'h7);
      foreach (b_tab[i])
      begin
         drive(b_tab[i]);
         tick();
      end
      chk({alarm_out, irq}, 2'b11);
      rdchk(`AWM_OFF_IRQ_STAT, 16'h0003);
      apb(1'b1, `AWM_OFF_IRQ_STAT, 32'h3);
      @(posedge pclk);
      chk({alarm_out, irq}, 2'b10);
      ctrl = 8'h0F;
      apb(1'b1, `AWM_OFF_CTRL, 32'(ctrl));
      power_loss_n <= 1'b0;
      repeat (2) @(posedge pclk);
      power_loss_n <= 1'b1;
      @(posedge pclk);
      chk(alarm_out, 1'b1);
      ctrl = 8'h0D;
      apb(1'b1, `AWM_OFF_CTRL, 32'(ctrl));
      power_loss_n <= 1'b0;
      repeat (2) @(posedge pclk);
      power_loss_n <= 1'b1;
      @(posedge pclk);
      chk(alarm_out, 1'b0);
      prev = 1'b0;
      drive(300);
      tick();
      drive(200);
      tick();
      rdchk(`AWM_OFF_REF, 16'h012C);
      rdchk(`AWM_OFF_LIVE, 16'h00C8);
      rdchk(`AWM_OFF_IRQ_STAT, 16'h0007);
      chk({alarm_out, irq}, 2'b11);
      ctrl = 8'h00;
      apb(1'b1, `AWM_OFF_CTRL, 32'(ctrl));
      tick();
      finish_test();
   end

endmodule : test_analog_window_monitor
`default_nettype wire
